// >>> logic/serial_flash_program_erase_ctrl.sv
// Program and erase command sequencer behind the serial flash pins
`timescale 1ns/1ps
module serial_flash_program_erase_ctrl #(
  parameter int unsigned PROG_CYCLES = flash_seq_pkg::PROG_CYC,
  parameter int unsigned SSE_CYCLES  = flash_seq_pkg::SSE_CYC,
  parameter int unsigned SE_CYCLES   = flash_seq_pkg::SE_CYC
) (
  input  wire logic                                 clk,
  input  wire logic                                 rst,
  input  wire flash_seq_pkg::proto_t                protoSel,
  input  wire logic                                 csN,
  input  wire logic                                 sclk,
  input  wire logic [3:0]                           dq,
  input  wire logic [flash_seq_pkg::SECTORS-1:0]    sectorLock,
  input  wire logic                                 flagClear,
  output logic                                      wel,
  output logic                                      wip,
  output logic [7:0]                                flagStatus,
  output logic                                      wrValid,
  input  wire logic                                 wrReady,
  output logic [23:0]                               wrAddr,
  output logic [7:0]                                wrData,
  output logic                                      eraseValid,
  input  wire logic                                 eraseReady,
  output logic [23:0]                               eraseAddr,
  output logic                                      eraseSector
);
  logic [5:0]            pinS;
  logic                  csS;
  logic                  sclkS;
  logic [3:0]            dqS;
  logic                  csPrev_r;
  logic                  sclkPrev_r;
  logic                  csRise;
  logic                  csFall;
  logic                  sclkRise;
  flash_seq_pkg::phase_t phase_r;
  flash_seq_pkg::op_t    op_r;
  logic [7:0]            cmd_r;
  logic [7:0]            sh_r;
  logic [23:0]           addr_r;
  logic [3:0]            bitCnt_r;
  logic [1:0]            addrCnt_r;
  logic                  gotData_r;
  logic                  extra_r;
  logic [7:0]            off_r;
  logic [2:0]            lanes;
  logic [7:0]            newSh;
  logic [3:0]            newCnt;
  logic                  byteDone;
  logic                  dataByte;
  logic [7:0]            pageMem [256];
  logic [255:0]          pageVld_r;
  logic                  wel_r;
  logic                  susp_r;
  logic [23:0]           timer_r;
  logic [7:0]            scanIdx_r;
  logic                  scanDone_r;
  logic                  eraseValid_r;
  logic [23:0]           eraseAddr_r;
  logic                  eraseSector_r;
  logic [7:0]            flag_r;
  logic [7:0]            flagSet;
  logic [7:0]            flagClr;
  logic                  aligned;
  logic                  tailCmd;
  logic                  wrenOk;
  logic                  wrdiOk;
  logic                  lockHit;
  logic                  progEnd;
  logic                  progStart;
  logic                  progProt;
  logic                  eraseEnd;
  logic                  eraseStart;
  logic                  eraseProt;
  logic                  eraseNoWel;
  logic                  suspReq;
  logic                  resReq;
  logic                  running;
  logic                  opEnd;
  logic                  timeout;
  logic                  pushValid;
  logic                  pushReady;

  sync_2ff #(.W(6), .INIT(6'h20)) uSync (
    .clk (clk),
    .rst (rst),
    .d   ({csN, sclk, dq}),
    .q   (pinS)
  );

  assign csS   = pinS[5];
  assign sclkS = pinS[4];
  assign dqS   = pinS[3:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      csPrev_r   <= 1'b1;
      sclkPrev_r <= 1'b0;
    end else begin
      csPrev_r   <= csS;
      sclkPrev_r <= sclkS;
    end
  end

  assign csFall   = csPrev_r && !csS;
  assign csRise   = !csPrev_r && csS;
  assign sclkRise = !sclkPrev_r && sclkS && !csS;

  // Lane width per frame phase and command
  always_comb begin
    case (phase_r)
      flash_seq_pkg::PH_CMD:  lanes = flash_seq_pkg::laneCount(protoSel);
      flash_seq_pkg::PH_ADDR: begin
        if (protoSel != flash_seq_pkg::PROTO_EXT) lanes = flash_seq_pkg::laneCount(protoSel);
        else if (cmd_r == flash_seq_pkg::CMD_XDPP) lanes = 3'd2;
        else if (cmd_r == flash_seq_pkg::CMD_XQPP) lanes = 3'd4;
        else lanes = 3'd1;
      end
      flash_seq_pkg::PH_DATA: begin
        if (cmd_r == flash_seq_pkg::CMD_DPP || cmd_r == flash_seq_pkg::CMD_XDPP) lanes = 3'd2;
        else if (cmd_r == flash_seq_pkg::CMD_QPP || cmd_r == flash_seq_pkg::CMD_XQPP) lanes = 3'd4;
        else lanes = flash_seq_pkg::laneCount(protoSel);
      end
      default: lanes = 3'd1;
    endcase
  end

  assign newSh    = flash_seq_pkg::shiftIn(sh_r, dqS, lanes);
  assign newCnt   = bitCnt_r + {1'b0, lanes};
  assign byteDone = (newCnt == 4'd8);
  assign dataByte = sclkRise && byteDone && (phase_r == flash_seq_pkg::PH_DATA);

  // Frame parser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r   <= flash_seq_pkg::PH_CMD;
      cmd_r     <= 8'h00;
      sh_r      <= 8'h00;
      addr_r    <= 24'h000000;
      bitCnt_r  <= 4'h0;
      addrCnt_r <= 2'h0;
      gotData_r <= 1'b0;
      extra_r   <= 1'b0;
      off_r     <= 8'h00;
    end else if (csFall) begin
      phase_r   <= flash_seq_pkg::PH_CMD;
      bitCnt_r  <= 4'h0;
      addrCnt_r <= 2'h0;
      gotData_r <= 1'b0;
      extra_r   <= 1'b0;
    end else if (sclkRise) begin
      if (phase_r == flash_seq_pkg::PH_TAIL) begin
        extra_r <= 1'b1;
      end else begin
        sh_r     <= newSh;
        bitCnt_r <= byteDone ? 4'h0 : newCnt;
        if (byteDone) begin
          case (phase_r)
            flash_seq_pkg::PH_CMD: begin
              cmd_r   <= newSh;
              phase_r <= (flash_seq_pkg::isProg(newSh) || flash_seq_pkg::isErase(newSh)) ?
                         flash_seq_pkg::PH_ADDR : flash_seq_pkg::PH_TAIL;
            end
            flash_seq_pkg::PH_ADDR: begin
              addr_r    <= {addr_r[15:0], newSh};
              addrCnt_r <= addrCnt_r + 2'd1;
              if (addrCnt_r == 2'(flash_seq_pkg::ADDR_BYTES - 1)) begin
                off_r   <= newSh;
                phase_r <= flash_seq_pkg::isProg(cmd_r) ?
                           flash_seq_pkg::PH_DATA : flash_seq_pkg::PH_TAIL;
              end
            end
            flash_seq_pkg::PH_DATA: begin
              off_r     <= off_r + 8'd1;
              gotData_r <= 1'b1;
            end
            default: phase_r <= flash_seq_pkg::PH_TAIL;
          endcase
        end
      end
    end
  end

  // Page latch: later bytes overwrite earlier ones at the same offset
  always_ff @(posedge clk) begin
    if (dataByte && !wip) begin
      pageMem[off_r] <= newSh;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pageVld_r <= '0;
    end else if (csFall && !wip) begin
      pageVld_r <= '0;
    end else if (dataByte && !wip) begin
      pageVld_r[off_r] <= 1'b1;
    end
  end

  // Frame end decode
  assign aligned    = (bitCnt_r == 4'h0) && !extra_r;
  assign tailCmd    = csRise && (phase_r == flash_seq_pkg::PH_TAIL) && aligned;
  assign wrenOk     = tailCmd && (cmd_r == flash_seq_pkg::CMD_WREN) && !wip;
  assign wrdiOk     = tailCmd && (cmd_r == flash_seq_pkg::CMD_WRDI) && !wip;
  assign lockHit    = sectorLock[addr_r[flash_seq_pkg::SEC_MSB:flash_seq_pkg::SEC_LSB]];
  assign progEnd    = csRise && (phase_r == flash_seq_pkg::PH_DATA) && aligned && gotData_r &&
                      !wip && wel_r &&
                      !((protoSel == flash_seq_pkg::PROTO_QUAD) &&
                        (cmd_r == flash_seq_pkg::CMD_DPP || cmd_r == flash_seq_pkg::CMD_XDPP)) &&
                      !((protoSel == flash_seq_pkg::PROTO_DUAL) &&
                        (cmd_r == flash_seq_pkg::CMD_QPP || cmd_r == flash_seq_pkg::CMD_XQPP));
  assign progStart  = progEnd && !lockHit;
  assign progProt   = progEnd && lockHit;
  assign eraseEnd   = tailCmd && flash_seq_pkg::isErase(cmd_r) && !wip;
  assign eraseStart = eraseEnd && wel_r && !lockHit;
  assign eraseProt  = eraseEnd && wel_r && lockHit;
  assign eraseNoWel = eraseEnd && !wel_r;
  assign suspReq    = tailCmd && (cmd_r == flash_seq_pkg::CMD_SUSP) && wip && !susp_r;
  assign resReq     = tailCmd && (cmd_r == flash_seq_pkg::CMD_RES) && susp_r;

  assign running   = (op_r != flash_seq_pkg::OP_IDLE) && !susp_r;
  assign opEnd     = running && (timer_r == 24'h000000);
  assign timeout   = opEnd && ((op_r == flash_seq_pkg::OP_PROG) ? (!scanDone_r || wrValid) :
                               eraseValid_r);
  assign pushValid = running && (op_r == flash_seq_pkg::OP_PROG) && !scanDone_r &&
                     pageVld_r[scanIdx_r] && (timer_r != 24'h000000);

  // Self-timed operation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_r          <= flash_seq_pkg::OP_IDLE;
      timer_r       <= 24'h000000;
      susp_r        <= 1'b0;
      scanIdx_r     <= 8'h00;
      scanDone_r    <= 1'b0;
      eraseAddr_r   <= 24'h000000;
      eraseSector_r <= 1'b0;
    end else if (progStart) begin
      op_r       <= flash_seq_pkg::OP_PROG;
      timer_r    <= 24'(PROG_CYCLES);
      scanIdx_r  <= 8'h00;
      scanDone_r <= 1'b0;
    end else if (eraseStart) begin
      op_r          <= (cmd_r == flash_seq_pkg::CMD_SE) ? flash_seq_pkg::OP_SE : flash_seq_pkg::OP_SSE;
      timer_r       <= (cmd_r == flash_seq_pkg::CMD_SE) ? 24'(SE_CYCLES) : 24'(SSE_CYCLES);
      eraseSector_r <= (cmd_r == flash_seq_pkg::CMD_SE);
      eraseAddr_r   <= (cmd_r == flash_seq_pkg::CMD_SE) ?
                       {addr_r[23:flash_seq_pkg::SEC_LSB], 16'h0000} :
                       {addr_r[23:flash_seq_pkg::SUB_LSB], 12'h000};
    end else begin
      if (suspReq) susp_r <= 1'b1;
      else if (resReq) susp_r <= 1'b0;
      if (opEnd) begin
        op_r <= flash_seq_pkg::OP_IDLE;
      end else if (running) begin
        timer_r <= timer_r - 24'd1;
      end
      if (running && (op_r == flash_seq_pkg::OP_PROG) && !scanDone_r &&
          (!pageVld_r[scanIdx_r] || pushReady)) begin
        scanIdx_r <= scanIdx_r + 8'd1;
        if (scanIdx_r == 8'hff) scanDone_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eraseValid_r <= 1'b0;
    end else if (eraseStart) begin
      eraseValid_r <= 1'b1;
    end else if (opEnd || (eraseValid_r && eraseReady)) begin
      eraseValid_r <= 1'b0;
    end
  end

  pair_buffer #(.W(32), .DEPTH(flash_seq_pkg::BUF_DEPTH)) uBuf (
    .clk      (clk),
    .rst      (rst),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   ({addr_r[23:8], scanIdx_r, pageMem[scanIdx_r]}),
    .outValid (wrValid),
    .outReady (wrReady),
    .outData  ({wrAddr, wrData})
  );

  // Write enable latch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wel_r <= 1'b0;
    end else if (progStart || eraseStart || timeout || wrdiOk) begin
      wel_r <= 1'b0;
    end else if (wrenOk) begin
      wel_r <= 1'b1;
    end
  end

  // Flag status: hardware set wins over clear
  always_comb begin
    flagSet = 8'h00;
    flagClr = 8'h00;
    flagSet[flash_seq_pkg::FS_PROT]  = progProt || eraseProt;
    flagSet[flash_seq_pkg::FS_PFAIL] = progProt || (timeout && op_r == flash_seq_pkg::OP_PROG);
    flagSet[flash_seq_pkg::FS_EERR]  = eraseProt || (timeout && op_r != flash_seq_pkg::OP_PROG);
    flagSet[flash_seq_pkg::FS_PSUSP] = suspReq && (op_r == flash_seq_pkg::OP_PROG);
    flagSet[flash_seq_pkg::FS_ESUSP] = suspReq && (op_r != flash_seq_pkg::OP_PROG);
    flagClr[flash_seq_pkg::FS_PROT]  = flagClear;
    flagClr[flash_seq_pkg::FS_PFAIL] = flagClear;
    flagClr[flash_seq_pkg::FS_EERR]  = flagClear;
    flagClr[flash_seq_pkg::FS_PSUSP] = resReq || opEnd;
    flagClr[flash_seq_pkg::FS_ESUSP] = resReq || opEnd;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_r <= flash_seq_pkg::FLAG_RESET;
    end else begin
      flag_r <= (flag_r & ~flagClr) | flagSet;
    end
  end

  assign wel         = wel_r;
  assign wip         = (op_r != flash_seq_pkg::OP_IDLE);
  assign eraseValid  = eraseValid_r;
  assign eraseAddr   = eraseAddr_r;
  assign eraseSector = eraseSector_r;
  always_comb begin
    flagStatus = flag_r;
    flagStatus[flash_seq_pkg::FS_READY] = !wip || susp_r;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence sOpStart;
    progStart || eraseStart;
  endsequence
  sequence sBusyNoLatch;
    wip && !wel;
  endsequence
  sequence sRefused;
    wel && !wip && flag_r[flash_seq_pkg::FS_PROT];
  endsequence

  wel_set_a: assert property (wrenOk |=> wel ##1 wel || wrdiOk)
    else $error("Write enable did not latch");
  op_start_a: assert property (sOpStart |=> sBusyNoLatch ##1 wip)
    else $error("Operation start did not show busy with latch clear");
  prog_prot_a: assert property (progProt |=> sRefused and flag_r[flash_seq_pkg::FS_PFAIL])
    else $error("Locked program not refused correctly");
  erase_prot_a: assert property (eraseProt |=> sRefused and flag_r[flash_seq_pkg::FS_EERR])
    else $error("Locked erase not refused correctly");
  erase_nowel_a: assert property (eraseNoWel |=> !wip && $stable(flag_r))
    else $error("Erase without latch had an effect");
  bad_end_a: assert property (csRise && !aligned && !wip |=> !wip && wel == $past(wel))
    else $error("Misaligned frame end changed state");
  prog_tmo_a: assert property (timeout && op_r == flash_seq_pkg::OP_PROG
    |=> !wel && !wip && flag_r[flash_seq_pkg::FS_PFAIL])
    else $error("Program timeout not flagged");
  erase_tmo_a: assert property (timeout && op_r != flash_seq_pkg::OP_PROG
    |=> !wel && !wip && flag_r[flash_seq_pkg::FS_EERR])
    else $error("Erase timeout not flagged");
  page_wrap_a: assert property (dataByte && off_r == 8'hff && !csRise |=> off_r == 8'h00)
    else $error("Page offset did not wrap");
  same_page_a: assert property (wrValid && wip |-> wrAddr[23:8] == addr_r[23:8])
    else $error("Program write left the addressed page");
  erase_align_a: assert property (eraseStart && cmd_r == flash_seq_pkg::CMD_SSE
    |=> eraseValid && eraseAddr[11:0] == 12'h000)
    else $error("Subsector erase address not aligned");
  busy_hold_a: assert property (csRise && wip && timer_r > 24'd2 |=> wip && !wel)
    else $error("Command accepted while busy");
endmodule : serial_flash_program_erase_ctrl

// >>> logic/flash_seq_pkg.sv
// Shared constants, types and helpers for the flash program/erase sequencer
package flash_seq_pkg;

  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_WRDI = 8'h04;
  localparam logic [7:0] CMD_PP   = 8'h02;
  localparam logic [7:0] CMD_DPP  = 8'ha2;
  localparam logic [7:0] CMD_XDPP = 8'hd2;
  localparam logic [7:0] CMD_QPP  = 8'h32;
  localparam logic [7:0] CMD_XQPP = 8'h12;
  localparam logic [7:0] CMD_SSE  = 8'h20;
  localparam logic [7:0] CMD_SE   = 8'hd8;
  localparam logic [7:0] CMD_SUSP = 8'h75;
  localparam logic [7:0] CMD_RES  = 8'h7a;

  localparam int ADDR_BYTES = 3;
  localparam int SEC_LSB    = 16;
  localparam int SUB_LSB    = 12;
  localparam int SEC_MSB    = 20;
  localparam int SECTORS    = 32;
  localparam int BUF_DEPTH  = 2;

  localparam int FS_PROT  = 1;
  localparam int FS_PSUSP = 2;
  localparam int FS_PFAIL = 4;
  localparam int FS_EERR  = 5;
  localparam int FS_ESUSP = 6;
  localparam int FS_READY = 7;
  localparam logic [7:0] FLAG_RESET = 8'h00;

  localparam int unsigned CLK_MHZ         = 20;
  localparam int unsigned PROG_TIME_US    = 500;
  localparam int unsigned SSE_TIME_US     = 40000;
  localparam int unsigned SE_TIME_US      = 150000;
  localparam int unsigned PROG_CYC        = PROG_TIME_US * CLK_MHZ;
  localparam int unsigned SSE_CYC         = SSE_TIME_US * CLK_MHZ;
  localparam int unsigned SE_CYC          = SE_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {PROTO_EXT, PROTO_DUAL, PROTO_QUAD} proto_t;
  typedef enum logic [1:0] {PH_CMD, PH_ADDR, PH_DATA, PH_TAIL} phase_t;
  typedef enum logic [1:0] {OP_IDLE, OP_PROG, OP_SSE, OP_SE} op_t;

  function automatic logic [2:0] laneCount(input proto_t p);
    case (p)
      PROTO_DUAL: laneCount = 3'd2;
      PROTO_QUAD: laneCount = 3'd4;
      default:    laneCount = 3'd1;
    endcase
  endfunction : laneCount

  function automatic logic isProg(input logic [7:0] c);
    isProg = (c == CMD_PP) || (c == CMD_DPP) || (c == CMD_XDPP) ||
             (c == CMD_QPP) || (c == CMD_XQPP);
  endfunction : isProg

  function automatic logic isErase(input logic [7:0] c);
    isErase = (c == CMD_SSE) || (c == CMD_SE);
  endfunction : isErase

  function automatic logic [7:0] shiftIn(input logic [7:0] sh, input logic [3:0] d,
                                         input logic [2:0] w);
    case (w)
      3'd2:    shiftIn = {sh[5:0], d[1:0]};
      3'd4:    shiftIn = {sh[3:0], d};
      default: shiftIn = {sh[6:0], d[0]};
    endcase
  endfunction : shiftIn

endpackage : flash_seq_pkg

// >>> logic/sync_2ff.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync_2ff #(
  parameter int         W    = 1,
  parameter logic [5:0] INIT = 6'h00
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= INIT[W-1:0];
      q      <= INIT[W-1:0];
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : sync_2ff

// >>> logic/pair_buffer.sv
// Small valid/ready buffer between page scan and array write port
`timescale 1ns/1ps
module pair_buffer #(
  parameter int W     = 32,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic      [W-1:0] outData
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [PW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign inReady  = (cnt_r != (PW+1)'(DEPTH));
  assign outValid = (cnt_r != '0);
  assign outData  = mem[rp_r];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= inData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == PW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == PW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : pair_buffer

// >>> testbench/flash_host_model.sv
// Host controller model driving frames on the flash pins
`timescale 1ns/1ps
module flash_host_model (
  input  wire logic       clk,
  output logic            csN,
  output logic            sclk,
  output logic      [3:0] dq
);
  initial begin
    csN  = 1'b1;
    sclk = 1'b0;
    dq   = 4'h5;
  end
  // Lane groups MSB first, data set while the serial clock is low
  task automatic shift(input logic [7:0] v, input int w, input int n);
    for (int i = n - w; i >= 0; i -= w) begin
      dq = 4'((v >> i) & ((8'h1 << w) - 8'h1));
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      sclk = 1'b0;
    end
  endtask : shift
  // A nonzero extra adds one stray lane group before release
  task automatic frame(input logic [7:0] q[$], input int w, input int extra);
    @(negedge clk);
    csN = 1'b0;
    foreach (q[i]) shift(q[i], w, 8);
    if (extra != 0) shift(8'h00, w, w);
    repeat (4) @(negedge clk);
    csN = 1'b1;
    dq  = ~dq;
    repeat (8) @(negedge clk);
  endtask : frame
endmodule : flash_host_model

// >>> testbench/serial_flash_program_erase_ctrl_test.sv
// Self-checking bench for the program and erase sequencer
`timescale 1ns/1ps
module serial_flash_program_erase_ctrl_test;
  logic                  clk, rst, flagClear, wrReady, eraseReady, csN, sclk;
  logic                  wel, wip, wrValid, eraseValid, eraseSector;
  logic [3:0]            dq;
  logic [7:0]            flagStatus, wrData;
  logic [23:0]           wrAddr, eraseAddr;
  logic [31:0]           sectorLock;
  logic [31:0]           wrLog[$];
  flash_seq_pkg::proto_t protoSel;
  int                    n_fail, compares;

  flash_host_model host_u (.clk(clk), .csN(csN), .sclk(sclk), .dq(dq));
  serial_flash_program_erase_ctrl #(.PROG_CYCLES(400), .SSE_CYCLES(80), .SE_CYCLES(100)) dut_u (
    .clk(clk), .rst(rst), .protoSel(protoSel), .csN(csN), .sclk(sclk), .dq(dq),
    .sectorLock(sectorLock), .flagClear(flagClear), .wel(wel), .wip(wip),
    .flagStatus(flagStatus), .wrValid(wrValid), .wrReady(wrReady), .wrAddr(wrAddr),
    .wrData(wrData), .eraseValid(eraseValid), .eraseReady(eraseReady),
    .eraseAddr(eraseAddr), .eraseSector(eraseSector));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (wrValid === 1'b1 && wrReady === 1'b1) wrLog.push_back({wrAddr, wrData});

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic waitIdle();
    int k;
    for (k = 0; k < 3000 && wip !== 1'b0; k++) @(negedge clk);
    if (k == 3000) begin
      n_fail++;
      summarize();
    end
  endtask : waitIdle
  task automatic wren();
    host_u.frame('{8'h06}, 1, 0);
  endtask : wren
  task automatic clr();
    flagClear = 1'b1;
    @(negedge clk);
    flagClear = 1'b0;
  endtask : clr

  initial begin
    rst        = 1'b1;
    protoSel   = flash_seq_pkg::PROTO_EXT;
    flagClear  = 1'b0;
    wrReady    = 1'b0;
    eraseReady = 1'b0;
    sectorLock = 32'h0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    host_u.frame('{8'h06}, 1, 1);
    chk(wel, 1'b0);
    protoSel = flash_seq_pkg::PROTO_QUAD;
    host_u.frame('{8'h06}, 4, 0);
    chk(wel, 1'b1);
    protoSel = flash_seq_pkg::PROTO_DUAL;
    host_u.frame('{8'h04}, 2, 0);
    chk(wel, 1'b0);
    protoSel = flash_seq_pkg::PROTO_EXT;
    host_u.frame('{8'hd8, 8'h01, 8'h23, 8'h45}, 1, 0);
    chk({wip, eraseValid, flagStatus}, 10'h080);
    $display("Test latch done");
    wren();
    host_u.frame('{8'h02, 8'h00, 8'h01, 8'hfe, 8'h11, 8'h22, 8'h33}, 1, 0);
    chk({wip, wel, flagStatus[7]}, 3'b100);
    repeat (20) @(negedge clk);
    wrReady = 1'b1;
    waitIdle();
    chk(wrLog.size(), 3);
    chk(wrLog[0], 32'h00010033);
    chk(wrLog[1], 32'h0001fe11);
    chk({wip, flagStatus}, 9'h080);
    wrReady = 1'b0;
    wren();
    host_u.frame('{8'h02, 8'h00, 8'h02, 8'h00, 8'h5a}, 1, 0);
    waitIdle();
    chk({wel, flagStatus}, 9'h090);
    wrReady = 1'b1;
    clr();
    $display("Test program done");
    protoSel = flash_seq_pkg::PROTO_DUAL;
    host_u.frame('{8'h06}, 2, 0);
    host_u.frame('{8'h32, 8'h00, 8'h03, 8'h10, 8'h77}, 2, 0);
    chk({wip, wel}, 2'b01);
    host_u.frame('{8'ha2, 8'h00, 8'h03, 8'h10, 8'h77}, 2, 0);
    chk({wip, wel}, 2'b10);
    waitIdle();
    chk(wrLog[$], 32'h00031077);
    protoSel = flash_seq_pkg::PROTO_QUAD;
    host_u.frame('{8'h06}, 4, 0);
    host_u.frame('{8'h12, 8'h00, 8'h04, 8'h20, 8'hc3}, 4, 0);
    host_u.frame('{8'h75}, 4, 0);
    chk({wip, flagStatus}, 9'h184);
    host_u.frame('{8'h06}, 4, 0);
    chk(wel, 1'b0);
    host_u.frame('{8'h7a}, 4, 0);
    chk({wip, flagStatus}, 9'h100);
    waitIdle();
    chk(wrLog[$], 32'h000420c3);
    protoSel = flash_seq_pkg::PROTO_EXT;
    $display("Test lanes done");
    for (int k = 0; k < 2; k++) begin
      wren();
      host_u.frame('{k ? 8'hd8 : 8'h20, 8'h01, 8'h23, 8'h45}, 1, 0);
      chk({wip, wel, eraseValid, eraseSector}, {3'b101, k[0]});
      chk(eraseAddr, k ? 24'h010000 : 24'h012000);
      eraseReady = (k == 0);
      @(negedge clk);
      eraseReady = 1'b0;
      waitIdle();
      chk({wel, eraseValid, flagStatus}, k ? 10'h0a0 : 10'h080);
    end
    clr();
    sectorLock = 32'h00000002;
    wren();
    host_u.frame('{8'h20, 8'h01, 8'h23, 8'h45}, 1, 0);
    chk({wip, wel, flagStatus}, 10'h1a2);
    host_u.frame('{8'h02, 8'h01, 8'h00, 8'h00, 8'haa}, 1, 0);
    chk({wip, wel, flagStatus}, 10'h1b2);
    host_u.frame('{8'h02, 8'h00, 8'h00, 8'h00, 8'h11}, 1, 1);
    chk({wip, wel, flagStatus}, 10'h1b2);
    $display("Test erase done");
    summarize();
  end
endmodule : serial_flash_program_erase_ctrl_test
